/* File: sync_off_io_defs.svh */
// register map, field positions, reset values and timing counts
`ifndef SYNC_OFF_IO_DEFS_SVH
`define SYNC_OFF_IO_DEFS_SVH

`define SOIO_CLK_PERIOD_NS 5
`define SOIO_MIN_LOW_NS    30000
`define SOIO_MIN_LOW_CYC   ((`SOIO_MIN_LOW_NS + `SOIO_CLK_PERIOD_NS - 1) / `SOIO_CLK_PERIOD_NS)
`define SOIO_GUARD_CYC     4'h3

`define SOIO_ADDR_CTRL     5'h00
`define SOIO_ADDR_PERIOD   5'h04
`define SOIO_ADDR_HIGH     5'h08
`define SOIO_ADDR_STATUS   5'h0C
`define SOIO_ADDR_EVENT    5'h10

`define SOIO_CTRL_FUNC_LSB 0
`define SOIO_CTRL_INV_BIT  2
`define SOIO_CTRL_SRC_LSB  3
`define SOIO_CTRL_RST      5'h00

`define SOIO_PERIOD_RST    24'h030D40
`define SOIO_HIGH_RST      24'h0186A0

`define SOIO_EVT_RX        0
`define SOIO_EVT_IGN       1
`define SOIO_EVT_TX        2
`define SOIO_EVT_NUM       3

`endif

/* File: sync_off_io_pkg.sv */
// types shared by the sync-off pin block
package sync_off_io_pkg;

  typedef enum logic [1:0] {
    FUNC_SYNC   = 2'h0,
    FUNC_INPUT  = 2'h1,
    FUNC_OUTPUT = 2'h2
  } func_t;

  typedef enum logic [1:0] {
    SRC_ONE  = 2'h0,
    SRC_ZERO = 2'h1,
    SRC_PWM  = 2'h2
  } out_src_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_EMIT  = 3'h2,
    ST_GUARD = 3'h4
  } sync_state_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

endpackage : sync_off_io_pkg

/* File: sync_off_io_pwm.sv */
// pwm waveform generator with period and high time in clock cycles
`timescale 1ns/1ps
`default_nettype none

module sync_off_io_pwm (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [23:0] period_cyc,
  input  wire logic [23:0] high_cyc,
  output logic             wave
);

  logic [23:0] cnt_reg;
  logic [23:0] cnt_next;
  logic        wave_next;
  wire         period_zero = (period_cyc == 24'h000000);
  wire         at_end      = (cnt_reg >= period_cyc - 24'h000001);

  // zero period parks the output low
  assign cnt_next  = (period_zero || at_end) ? 24'h000000 : cnt_reg + 24'h000001;
  assign wave_next = !period_zero && (cnt_reg < high_cyc);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 24'h000000;
      wave    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      wave    <= wave_next;
    end
  end

  AST_PWM_WRAP: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!period_zero && cnt_reg == period_cyc - 24'h000001 && $stable(period_cyc))
      |=> (cnt_reg == 24'h000000)
      ##1 (wave == ($past(high_cyc) != 24'h000000 && $past(period_cyc) != 24'h000000)))
    else $error("pwm period did not wrap");

endmodule : sync_off_io_pwm

`default_nettype wire

/* File: sync_off_io_pin.sv */
// configurable sync-off / level input / output pin with register port
//
// How it works
// - pin function selects turn-off sync, level input or general output
// - turn-off sync is the reset function and is bidirectional
// - invert setting flips input and output polarity, otherwise unchanged
// - level input mode samples the pin as an external level
// - output mode drives constant one, constant zero or pwm
// - logic one drives pin low, or high when inverted
// - pwm frequency and duty each come from their own register
// - in sync mode a switch on-to-off change emits a pulse
// - in sync mode a pulse seen while switch is off is ignored
// - in sync mode a pulse seen while switch is on turns it off
//
// Design decisions made here: the placing of the registers and the strobed register port.
`include "sync_off_io_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sync_off_io_pin #(
  parameter int unsigned MIN_LOW_CYC = `SOIO_MIN_LOW_CYC
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire sync_off_io_pkg::bus_req_t bus_req,
  output logic [31:0]                    bus_rdata,
  input  wire logic                      sw_on,
  output logic                           sw_off_req,
  input  wire logic                      pin_in,
  output logic                           pin_out,
  output logic                           pin_oe
);

  localparam logic [15:0] MIN_M1 = 16'(MIN_LOW_CYC - 1);

  function automatic logic addr_hit(input logic [4:0] a, input logic [4:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  // register state
  logic [4:0]  ctrl_reg;
  logic [23:0] period_reg;
  logic [23:0] high_reg;
  logic [2:0]  evt_reg;
  logic [31:0] rdata_reg;

  // pin and switch state
  logic        pin_meta_reg;
  logic        pin_sync_reg;
  logic        sw_on_d_reg;
  logic        in_level_reg;
  logic [15:0] filt_cnt_reg;
  logic [15:0] filt_cnt_next;
  logic [15:0] emit_cnt_reg;
  logic [15:0] emit_cnt_next;
  logic [3:0]  guard_cnt_reg;
  logic [3:0]  guard_cnt_next;
  logic        off_req_reg;

  sync_off_io_pkg::sync_state_t state_reg;
  sync_off_io_pkg::sync_state_t state_next;

  // field decode
  wire sync_off_io_pkg::func_t    func_sel =
    sync_off_io_pkg::func_t'(ctrl_reg[`SOIO_CTRL_FUNC_LSB +: 2]);
  wire sync_off_io_pkg::out_src_t src_sel  =
    sync_off_io_pkg::out_src_t'(ctrl_reg[`SOIO_CTRL_SRC_LSB +: 2]);
  wire inv        = ctrl_reg[`SOIO_CTRL_INV_BIT];
  wire mode_sync  = (func_sel == sync_off_io_pkg::FUNC_SYNC);
  wire mode_input = (func_sel == sync_off_io_pkg::FUNC_INPUT);
  wire mode_out   = (func_sel == sync_off_io_pkg::FUNC_OUTPUT);

  // bus decode
  wire wr_ctrl   = bus_req.wr && addr_hit(bus_req.addr, `SOIO_ADDR_CTRL);
  wire wr_period = bus_req.wr && addr_hit(bus_req.addr, `SOIO_ADDR_PERIOD);
  wire wr_high   = bus_req.wr && addr_hit(bus_req.addr, `SOIO_ADDR_HIGH);
  wire wr_event  = bus_req.wr && addr_hit(bus_req.addr, `SOIO_ADDR_EVENT);

  // pin level to logic level: active logic one is a low pin unless inverted
  wire in_active = pin_sync_reg ^ ~inv;

  // on-to-off edge of the local input switch
  wire sw_fall = sw_on_d_reg && !sw_on;

  // glitch filter: accept only after the full minimum low time
  wire filt_run = mode_sync && (state_reg == sync_off_io_pkg::ST_IDLE) && in_active;
  wire rx_fire  = filt_run && (filt_cnt_reg == MIN_M1);
  wire rx_take  = rx_fire && sw_on;
  wire rx_ign   = rx_fire && !sw_on;

  always_comb begin
    filt_cnt_next = 16'h0000;
    if (filt_run && !sw_fall) begin
      // saturate so one long low gives one event only
      filt_cnt_next = (filt_cnt_reg > MIN_M1) ? filt_cnt_reg : filt_cnt_reg + 16'h0001;
    end
  end

  // emit sequencer
  wire emit_done  = (emit_cnt_reg == MIN_M1);
  wire guard_done = (guard_cnt_reg >= `SOIO_GUARD_CYC);

  always_comb begin
    state_next     = state_reg;
    emit_cnt_next  = 16'h0000;
    guard_cnt_next = 4'h0;
    case (state_reg)
      sync_off_io_pkg::ST_IDLE: begin
        if (mode_sync && sw_fall) begin
          state_next = sync_off_io_pkg::ST_EMIT;
        end
      end
      sync_off_io_pkg::ST_EMIT: begin
        emit_cnt_next = emit_cnt_reg + 16'h0001;
        if (!mode_sync) begin
          state_next = sync_off_io_pkg::ST_IDLE;
        end else if (emit_done) begin
          state_next = sync_off_io_pkg::ST_GUARD;
        end
      end
      sync_off_io_pkg::ST_GUARD: begin
        // own pulse echoes through the synchroniser; wait until it clears
        guard_cnt_next = guard_done ? guard_cnt_reg : guard_cnt_reg + 4'h1;
        if (!mode_sync || (guard_done && !in_active)) begin
          state_next = sync_off_io_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = sync_off_io_pkg::ST_IDLE;
      end
    endcase
  end

  // logic value to place on the pin and whether to drive it
  logic drive_logic;
  logic drive_en;
  logic pwm_wave;

  always_comb begin
    drive_logic = 1'b0;
    drive_en    = 1'b0;
    if (mode_sync) begin
      drive_logic = (state_reg == sync_off_io_pkg::ST_EMIT);
      drive_en    = (state_reg == sync_off_io_pkg::ST_EMIT);
    end else if (mode_out) begin
      drive_en = 1'b1;
      case (src_sel)
        sync_off_io_pkg::SRC_ONE:  drive_logic = 1'b1;
        sync_off_io_pkg::SRC_ZERO: drive_logic = 1'b0;
        sync_off_io_pkg::SRC_PWM:  drive_logic = pwm_wave;
        default:                   drive_logic = 1'b0;
      endcase
    end
  end

  // logic one drives low, logic zero drives high, swapped when inverted
  wire pin_level_next = drive_logic ^ ~inv;

  sync_off_io_pwm u_pwm (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .period_cyc (period_reg),
    .high_cyc   (high_reg),
    .wave       (pwm_wave)
  );

  // event flags: hardware set wins over write-one-to-clear
  wire [2:0] evt_set;
  assign evt_set[`SOIO_EVT_RX]  = rx_take;
  assign evt_set[`SOIO_EVT_IGN] = rx_ign;
  assign evt_set[`SOIO_EVT_TX]  = (state_reg == sync_off_io_pkg::ST_EMIT) && emit_done;

  genvar gi;
  generate
    for (gi = 0; gi < `SOIO_EVT_NUM; gi = gi + 1) begin : g_evt
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          evt_reg[gi] <= 1'b0;
        end else if (evt_set[gi]) begin
          evt_reg[gi] <= 1'b1;
        end else if (wr_event && bus_req.wdata[gi]) begin
          evt_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // read mux
  wire [31:0] status_word = {29'h00000000,
                             (state_reg == sync_off_io_pkg::ST_EMIT),
                             sw_on_d_reg,
                             in_level_reg};
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h00000000;
    if (addr_hit(bus_req.addr, `SOIO_ADDR_CTRL)) begin
      rd_mux = {27'h0000000, ctrl_reg};
    end else if (addr_hit(bus_req.addr, `SOIO_ADDR_PERIOD)) begin
      rd_mux = {8'h00, period_reg};
    end else if (addr_hit(bus_req.addr, `SOIO_ADDR_HIGH)) begin
      rd_mux = {8'h00, high_reg};
    end else if (addr_hit(bus_req.addr, `SOIO_ADDR_STATUS)) begin
      rd_mux = status_word;
    end else if (addr_hit(bus_req.addr, `SOIO_ADDR_EVENT)) begin
      rd_mux = {29'h00000000, evt_reg};
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg   <= `SOIO_CTRL_RST;
      period_reg <= `SOIO_PERIOD_RST;
      high_reg   <= `SOIO_HIGH_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= bus_req.wdata[4:0];
      end
      if (wr_period) begin
        period_reg <= bus_req.wdata[23:0];
      end
      if (wr_high) begin
        high_reg <= bus_req.wdata[23:0];
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= bus_req.rd ? rd_mux : 32'h00000000;
    end
  end

  // pin synchroniser, level sample and switch edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      in_level_reg <= 1'b0;
      sw_on_d_reg  <= 1'b0;
    end else begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
      in_level_reg <= in_active;
      sw_on_d_reg  <= sw_on;
    end
  end

  // sequencer, filter and outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= sync_off_io_pkg::ST_IDLE;
      filt_cnt_reg  <= 16'h0000;
      emit_cnt_reg  <= 16'h0000;
      guard_cnt_reg <= 4'h0;
      off_req_reg   <= 1'b0;
      pin_out       <= 1'b1;
      pin_oe        <= 1'b0;
    end else begin
      state_reg     <= state_next;
      filt_cnt_reg  <= filt_cnt_next;
      emit_cnt_reg  <= emit_cnt_next;
      guard_cnt_reg <= guard_cnt_next;
      off_req_reg   <= rx_take;
      pin_out       <= pin_level_next;
      pin_oe        <= drive_en;
    end
  end

  assign bus_rdata  = rdata_reg;
  assign sw_off_req = off_req_reg;

  // checking helpers: run lengths of drive and of incoming low
  logic [15:0] oe_run_reg;
  logic [15:0] act_run_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oe_run_reg  <= 16'h0000;
      act_run_reg <= 16'h0000;
    end else begin
      oe_run_reg  <= !pin_oe ? 16'h0000 :
                     (oe_run_reg == 16'hFFFF) ? oe_run_reg : oe_run_reg + 16'h0001;
      act_run_reg <= !in_active ? 16'h0000 :
                     (act_run_reg == 16'hFFFF) ? act_run_reg : act_run_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_DRIVE_LEGAL_FUNC: assert property (
    pin_oe |-> $past(mode_sync || mode_out))
    else $error("pin driven in a function that must not drive");

  AST_INPUT_NO_DRIVE: assert property (
    $past(mode_input) |-> !pin_oe)
    else $error("pin driven in level input function");

  AST_SYNC_EMIT_START: assert property (
    (mode_sync && sw_fall && state_reg == sync_off_io_pkg::ST_IDLE && !wr_ctrl)
      |=> (state_reg == sync_off_io_pkg::ST_EMIT) ##1 pin_oe)
    else $error("switch turn-off did not start a pulse");

  AST_EMIT_LENGTH: assert property (
    ($fell(pin_oe) && $past(mode_sync, 2) && $past(mode_sync))
      |-> (oe_run_reg >= 16'(MIN_LOW_CYC)))
    else $error("emitted pulse shorter than minimum low time");

  AST_TAKE_ON_PULSE: assert property (
    rx_fire && sw_on |=> sw_off_req ##1 !sw_off_req)
    else $error("accepted pulse did not request switch off");

  AST_IGNORE_WHEN_OFF: assert property (
    sw_off_req |-> $past(sw_on) && !$past(rx_ign))
    else $error("switch-off request while switch already off");

  AST_FILTER_MIN_LOW: assert property (
    sw_off_req |-> ($past(act_run_reg) >= MIN_M1) && $past(in_active))
    else $error("pulse accepted before minimum low time");

  AST_OUT_ONE_NORMAL: assert property (
    $past(mode_out && src_sel == sync_off_io_pkg::SRC_ONE && !inv) |-> pin_oe && !pin_out)
    else $error("logic one not driven low with normal polarity");

  AST_OUT_ONE_INVERT: assert property (
    $past(mode_out && src_sel == sync_off_io_pkg::SRC_ONE && inv) |-> pin_oe && pin_out)
    else $error("logic one not driven high when inverted");

  AST_OUT_ZERO: assert property (
    $past(mode_out && src_sel == sync_off_io_pkg::SRC_ZERO) |-> pin_out == !$past(inv))
    else $error("logic zero driven at the wrong level");

  AST_OUT_PWM: assert property (
    $past(mode_out && src_sel == sync_off_io_pkg::SRC_PWM)
      |-> pin_oe && (pin_out == ($past(pwm_wave) ^ !$past(inv))))
    else $error("pwm source not reaching the pin");

  AST_SYNC_IDLE_RELEASE: assert property (
    (mode_sync && state_reg == sync_off_io_pkg::ST_IDLE && !wr_ctrl) |=> !pin_oe)
    else $error("sync pin driven while no pulse is due");

endmodule : sync_off_io_pin

`default_nettype wire

/* File: sync_off_io_far.sv */
// far instrument model: open-drain low pulses on the sync-off line
`timescale 1ns/1ps
`default_nettype none

module sync_off_io_far (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [7:0] low_cyc,
  input  wire logic       hold_low,
  output logic            drive_low
);
  logic [7:0] left_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      left_reg <= 8'h00;
    end else if (start) begin
      left_reg <= low_cyc;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end

  // released line floats up to the pull-up level
  assign drive_low = hold_low | (left_reg != 8'h00);
endmodule : sync_off_io_far
`default_nettype wire

/* File: sync_off_io_pin_bench.sv */
// self-checking bench for the sync-off pin block
`include "sync_off_io_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sync_off_io_pin_bench;
  localparam int unsigned MIN_LOW = 20;
  typedef struct packed {
    logic [4:0] ctrl;
    logic       hold;
    logic       oe;
    logic       out;
    logic       lvl;
  } row_t;
  row_t rows [9] = '{'{5'h02, 1'b0, 1'b1, 1'b0, 1'b0}, '{5'h06, 1'b0, 1'b1, 1'b1, 1'b0},
                     '{5'h0A, 1'b0, 1'b1, 1'b1, 1'b0}, '{5'h0E, 1'b0, 1'b1, 1'b0, 1'b0},
                     '{5'h01, 1'b1, 1'b0, 1'b0, 1'b1}, '{5'h05, 1'b1, 1'b0, 1'b0, 1'b0},
                     '{5'h01, 1'b0, 1'b0, 1'b0, 1'b0}, '{5'h03, 1'b1, 1'b0, 1'b0, 1'b1},
                     '{5'h1A, 1'b0, 1'b1, 1'b1, 1'b0}};
  sync_off_io_pkg::bus_req_t bus_req;
  logic                      clk_sys;
  logic                      rst_n;
  logic                      sw_on;
  logic                      far_start;
  logic                      far_hold;
  logic [7:0]                far_len;
  logic [31:0]               bus_rdata;
  logic                      sw_off_req;
  logic                      pin_out;
  logic                      pin_oe;
  logic                      far_low;
  wire logic                 pin_in;
  logic [31:0]               d;
  logic [31:0]               n;
  int                        n_mismatch;
  int                        checked;
  int                        cyc;
  int                        n_off;
  int                        o;
  int                        per;

  assign pin_in = (pin_oe ? pin_out : 1'b1) & ~far_low;

  sync_off_io_pin #(.MIN_LOW_CYC(MIN_LOW)) sync_off_io_pin_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .sw_on(sw_on), .sw_off_req(sw_off_req), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe));

  sync_off_io_far sync_off_io_far_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .start(far_start), .low_cyc(far_len),
    .hold_low(far_hold), .drive_low(far_low));

  task automatic complete_run();
    $display("counts: %0d mismatches, %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic bus_wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [4:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1;
    v = bus_rdata;
  endtask : bus_rd

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    bus_rd(a, v);
    check(v, exp, what);
  endtask : rd_chk

  task automatic far_pulse(input logic [7:0] len);
    @(posedge clk_sys);
    far_len   <= len;
    far_start <= 1'b1;
    @(posedge clk_sys);
    far_start <= 1'b0;
    repeat (40) @(posedge clk_sys);
  endtask : far_pulse

  // own pulse after a switch fall: length and driven level
  task automatic emit_check(input logic inv);
    logic [31:0] cnt;
    logic [31:0] bad;
    cnt = 32'h0;
    bad = 32'h0;
    sw_on <= 1'b1;
    repeat (60) @(posedge clk_sys);
    sw_on <= 1'b0;
    repeat (MIN_LOW + 10) begin
      @(posedge clk_sys);
      #1;
      if (pin_oe === 1'b1) begin
        cnt++;
        if (pin_out !== inv) bad++;
      end
    end
    check(cnt, MIN_LOW, "emitted pulse length");
    check(bad, 32'h0, "emitted pulse level");
  endtask : emit_check

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (sw_off_req === 1'b1) n_off++;
    if (cyc == 4000) begin
      n_mismatch++;
      $display("BAD %0t run did not finish in time", $time);
      complete_run();
    end
  end

  initial begin
    rst_n     = 1'b0;
    bus_req   = '0;
    sw_on     = 1'b0;
    far_start = 1'b0;
    far_hold  = 1'b0;
    far_len   = 8'h00;
    repeat (11) @(posedge clk_sys);
    #1;
    check({31'h0, pin_oe}, 32'h0, "drive during reset");
    @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(`SOIO_ADDR_CTRL, 32'h0, "ctrl reset");
    rd_chk(`SOIO_ADDR_PERIOD, 32'h00030D40, "period reset");
    rd_chk(`SOIO_ADDR_HIGH, 32'h000186A0, "high reset");
    rd_chk(5'h14, 32'h0, "unmapped read");
    foreach (rows[i]) begin
      far_hold <= rows[i].hold;
      bus_wr(`SOIO_ADDR_CTRL, {27'h0, rows[i].ctrl});
      repeat (4) @(posedge clk_sys);
      #1;
      check({31'h0, pin_oe}, {31'h0, rows[i].oe}, "pin drive");
      if (rows[i].oe) check({31'h0, pin_out}, {31'h0, rows[i].out}, "pin level");
      if (!rows[i].oe) begin
        bus_rd(`SOIO_ADDR_STATUS, d);
        check({31'h0, d[0]}, {31'h0, rows[i].lvl}, "level input");
      end
    end
    far_hold <= 1'b0;
    for (int h = 3; h < 10; h += 4) begin
      per = (h < 5) ? 10 : 8;
      bus_wr(`SOIO_ADDR_PERIOD, per);
      bus_wr(`SOIO_ADDR_HIGH, h);
      bus_wr(`SOIO_ADDR_CTRL, 32'h00000012);
      repeat (30) @(posedge clk_sys);
      n = 32'h0;
      repeat (40) begin
        @(posedge clk_sys);
        #1;
        if (pin_out === 1'b0) n++;
      end
      check(n, (40 / per) * h, "pwm one cycles");
    end
    bus_wr(`SOIO_ADDR_PERIOD, 32'h0);
    repeat (4) @(posedge clk_sys);
    #1;
    check({30'h0, pin_oe, pin_out}, 32'h3, "pwm parked on zero period");
    bus_wr(`SOIO_ADDR_CTRL, 32'h0);
    bus_wr(`SOIO_ADDR_EVENT, 32'h7);
    emit_check(1'b0);
    repeat (20) @(posedge clk_sys);
    rd_chk(`SOIO_ADDR_EVENT, 32'h4, "own pulse event");
    bus_wr(`SOIO_ADDR_EVENT, 32'h7);
    rd_chk(`SOIO_ADDR_EVENT, 32'h0, "events cleared");
    sw_on <= 1'b1;
    o = n_off;
    far_pulse(8'(MIN_LOW));
    check(n_off, o + 1, "off request on pulse");
    rd_chk(`SOIO_ADDR_EVENT, 32'h1, "accepted event");
    bus_wr(`SOIO_ADDR_EVENT, 32'h7);
    far_pulse(8'(MIN_LOW - 1));
    check(n_off, o + 1, "short pulse filtered");
    rd_chk(`SOIO_ADDR_EVENT, 32'h0, "no event on glitch");
    sw_on <= 1'b0;
    repeat (80) @(posedge clk_sys);
    bus_wr(`SOIO_ADDR_EVENT, 32'h7);
    far_pulse(8'(MIN_LOW + 5));
    check(n_off, o + 1, "pulse while off");
    rd_chk(`SOIO_ADDR_EVENT, 32'h2, "ignored event");
    bus_wr(`SOIO_ADDR_CTRL, 32'h4);
    far_hold <= 1'b1;
    emit_check(1'b1);
    // reset again mid-run: outputs park and control returns to sync
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check({29'h0, pin_out, pin_oe, sw_off_req}, 32'h4, "outputs in reset");
    @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(`SOIO_ADDR_CTRL, 32'h0, "ctrl after reset");
    complete_run();
  end
endmodule : sync_off_io_pin_bench
`default_nettype wire
